// *** rtl/qrdc_top.sv ***
// quad fetch read engine with programmable dummy cycles and register slave
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "qrdc_map.svh"
module qrdc_top
   import qrdc_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // register bus
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial link
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output var  logic [3:0]  io_out,
   output var  logic [3:0]  io_oe
);
   function automatic qrdc_sel_e reg_sel(input logic [11:0] a);
      if (a == `QRDC_SR5_OFFS) reg_sel = SEL_SR5;
      else if (a == `QRDC_STAT_OFFS) reg_sel = SEL_STAT;
      else if (a >= `QRDC_MEM_BASE && a <= `QRDC_MEM_LAST && a[1:0] == 2'h0) reg_sel = SEL_MEM;
      else reg_sel = SEL_NONE;
   endfunction : reg_sel

   // pin synchroniser: s1 -> s2 -> s3, filtered when s2 and s3 agree
   logic [5:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
   logic [5:0] filt_nxt;
   always_comb begin
      filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_r     <= `QRDC_PIN_RST;
         s2_r     <= `QRDC_PIN_RST;
         s3_r     <= `QRDC_PIN_RST;
         filt_r   <= `QRDC_PIN_RST;
         filt_d_r <= `QRDC_PIN_RST;
      end else begin
         s1_r     <= {cs_n, sck, io_in};
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         filt_r   <= filt_nxt;
         filt_d_r <= filt_r;
      end
   end

   logic       sck_rise, sck_fall, cs_fall, cs_hi;
   logic [3:0] io_q;
   assign sck_rise = filt_r[`QRDC_PIN_SCK] & ~filt_d_r[`QRDC_PIN_SCK];
   assign sck_fall = ~filt_r[`QRDC_PIN_SCK] & filt_d_r[`QRDC_PIN_SCK];
   assign cs_fall  = ~filt_r[`QRDC_PIN_CS] & filt_d_r[`QRDC_PIN_CS];
   assign cs_hi    = filt_r[`QRDC_PIN_CS];
   assign io_q     = filt_r[3:0];

   // register bus state
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic        aw_held_r, w_held_r, aw_held_nxt, w_held_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0]  wstrb_r, wstrb_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0]  sr5_r, sr5_nxt;
   logic        mem_we;
   logic [31:0] stat_word;

   // fetch engine state
   qrdc_state_e state_r, state_nxt;
   logic [3:0]  cnt_r, cnt_nxt, dtarget_r, dtarget_nxt;
   logic [7:0]  cmd_r, cmd_nxt, mode_r, mode_nxt, cur_byte;
   logic [23:0] addr_r, addr_nxt, addr_shift;
   logic        aligned_cmd_r, aligned_cmd_nxt, xip_r, xip_nxt, nib_hi_r, nib_hi_nxt;
   logic [3:0]  io_out_r, io_out_nxt, io_oe_r, io_oe_nxt;
   logic [31:0] mem_word;
   logic [2:0]  dc_sel;
   logic        dwa_sel;

   assign dc_sel  = sr5_r[`QRDC_DC_MSB:`QRDC_DC_LSB]; // RQ1
   assign dwa_sel = sr5_r[`QRDC_DWA_BIT]; // RQ4

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[`QRDC_ST_XIP] = xip_r;
      stat_word[`QRDC_ST_ACT] = ~cs_hi;
      stat_word[`QRDC_ST_STATE_LSB +: 3] = state_r;
      stat_word[`QRDC_ST_CMD_LSB +: 8] = cmd_r;
   end

   always_comb begin
      aw_held_nxt = aw_held_r | (s_axi_awvalid & awready_r);
      awaddr_nxt  = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
      w_held_nxt  = w_held_r | (s_axi_wvalid & wready_r);
      wdata_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
      wstrb_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
      bvalid_nxt  = bvalid_r & ~s_axi_bready;
      bresp_nxt   = bresp_r;
      sr5_nxt     = sr5_r;
      mem_we      = 1'b0;
      if (aw_held_r && w_held_r && !bvalid_r) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = `QRDC_RESP_OKAY;
         if (reg_sel(awaddr_r) == SEL_SR5) begin
            if (wstrb_r[0]) sr5_nxt = wdata_r[7:0] & `QRDC_SR5_WMASK;
         end else if (reg_sel(awaddr_r) == SEL_MEM) begin
            mem_we = 1'b1;
         end else if (reg_sel(awaddr_r) == SEL_NONE) begin
            bresp_nxt = `QRDC_RESP_SLVERR;
         end
      end
      awready_nxt = ~aw_held_nxt;
      wready_nxt  = ~w_held_nxt;
      rvalid_nxt  = rvalid_r & ~s_axi_rready;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = `QRDC_RESP_OKAY;
         rdata_nxt  = 32'h0000_0000;
         if (reg_sel(s_axi_araddr) == SEL_SR5) rdata_nxt = {24'h000000, sr5_r};
         else if (reg_sel(s_axi_araddr) == SEL_STAT) rdata_nxt = stat_word;
         else if (reg_sel(s_axi_araddr) == SEL_NONE) rresp_nxt = `QRDC_RESP_SLVERR;
      end
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         arready_r <= 1'b1;
         bvalid_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 12'h000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bresp_r   <= `QRDC_RESP_OKAY;
         rresp_r   <= `QRDC_RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
         sr5_r     <= `QRDC_SR5_RST;
      end else begin
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         arready_r <= arready_nxt;
         bvalid_r  <= bvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         bresp_r   <= bresp_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         sr5_r     <= sr5_nxt;
      end
   end

   // word fetch runs ahead; a link edge is many clocks away, so one cycle of read latency is free
   qrdc_mem u_mem (
      .clk     (ref_clk),
      .wr_en   (mem_we),
      .wr_be   (wstrb_r),
      .wr_addr (awaddr_r[`QRDC_MEM_AW+1:2]),
      .wr_data (wdata_r),
      .rd_addr (addr_r[`QRDC_MEM_AW+1:2]),
      .rd_data (mem_word)
   );

   assign cur_byte   = mem_word[{addr_r[1:0], 3'h0} +: 8];
   assign addr_shift = {addr_r[19:0], io_q};

   always_comb begin
      state_nxt       = state_r;
      cnt_nxt         = cnt_r;
      dtarget_nxt     = dtarget_r;
      cmd_nxt         = cmd_r;
      mode_nxt        = mode_r;
      addr_nxt        = addr_r;
      aligned_cmd_nxt = aligned_cmd_r;
      xip_nxt         = xip_r;
      nib_hi_nxt      = nib_hi_r;
      io_out_nxt      = io_out_r;
      io_oe_nxt       = io_oe_r;
      if (cs_hi) begin
         state_nxt = S_IDLE;
         io_oe_nxt = 4'h0;
      end else if (cs_fall) begin
         state_nxt = xip_r ? S_ADDR : S_CMD; // RQ9
         cnt_nxt   = 4'h0;
      end else begin
         case (state_r)
            S_CMD: if (sck_rise) begin
               cmd_nxt = {cmd_r[6:0], io_q[0]};
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == `QRDC_CMD_LAST_BIT) begin
                  cnt_nxt = 4'h0;
                  if (cmd_nxt == `QRDC_CMD_FETCH || cmd_nxt == `QRDC_CMD_FETCH_AL) begin
                     state_nxt       = S_ADDR;
                     aligned_cmd_nxt = (cmd_nxt == `QRDC_CMD_FETCH_AL);
                  end else begin
                     state_nxt = S_SKIP;
                  end
               end
            end
            S_ADDR: if (sck_rise) begin
               addr_nxt = addr_shift;
               cnt_nxt  = cnt_r + 4'h1;
               if (cnt_r == `QRDC_ADDR_LAST_NIB) begin
                  // E7h ignores the flag; EBh aligns only when it is set
                  if (aligned_cmd_r || dwa_sel) addr_nxt = addr_shift & `QRDC_ALIGN_MASK; // RQ5 RQ6 RQ10
                  addr_nxt    = addr_nxt & `QRDC_ARRAY_MASK;
                  cnt_nxt     = 4'h0;
                  dtarget_nxt = qrdc_dummy_count(dc_sel); // RQ1 RQ2
                  state_nxt   = S_DUMMY;
               end
            end
            S_DUMMY: if (sck_rise) begin
               cnt_nxt = cnt_r + 4'h1; // RQ12
               if (cnt_r < `QRDC_MODE_CYC) mode_nxt = {mode_r[3:0], io_q}; // RQ3
               if (cnt_nxt == dtarget_r) begin
                  state_nxt  = S_DATA; // RQ12
                  xip_nxt    = (mode_nxt[7:4] == `QRDC_XIP_KEEP); // RQ9
                  nib_hi_nxt = 1'b1;
               end
            end
            S_DATA: if (sck_fall) begin
               io_oe_nxt  = 4'hF; // RQ11
               io_out_nxt = nib_hi_r ? cur_byte[7:4] : cur_byte[3:0]; // RQ11
               nib_hi_nxt = ~nib_hi_r;
               if (!nib_hi_r) addr_nxt = (addr_r + 24'h000001) & `QRDC_ARRAY_MASK;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r       <= S_IDLE;
         cnt_r         <= 4'h0;
         dtarget_r     <= `QRDC_DC_CYC0;
         cmd_r         <= 8'h00;
         mode_r        <= 8'h00;
         addr_r        <= 24'h000000;
         aligned_cmd_r <= 1'b0;
         xip_r         <= 1'b0;
         nib_hi_r      <= 1'b1;
         io_out_r      <= 4'h0;
         io_oe_r       <= 4'h0;
      end else begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         dtarget_r     <= dtarget_nxt;
         cmd_r         <= cmd_nxt;
         mode_r        <= mode_nxt;
         addr_r        <= addr_nxt;
         aligned_cmd_r <= aligned_cmd_nxt;
         xip_r         <= xip_nxt;
         nib_hi_r      <= nib_hi_nxt;
         io_out_r      <= io_out_nxt;
         io_oe_r       <= io_oe_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign io_out        = io_out_r;
   assign io_oe         = io_oe_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_dummy_target: assert property ( // RQ1 RQ2
      state_r == S_ADDR && sck_rise && !cs_hi && !cs_fall && cnt_r == `QRDC_ADDR_LAST_NIB
         && $past(sr5_r[`QRDC_DC_MSB:`QRDC_DC_LSB]) == sr5_r[`QRDC_DC_MSB:`QRDC_DC_LSB]
         && sr5_r[`QRDC_DC_MSB] == 1'b0
      |=> dtarget_r == {$past(sr5_r[`QRDC_DC_MSB-1:`QRDC_DC_LSB]), 1'b0} + `QRDC_DC_CYC0 && state_r == S_DUMMY)
      else $error("dummy target does not match select code");
   a_dummy_done: assert property ( // RQ12
      state_r == S_DUMMY && sck_rise && !cs_hi && !cs_fall && cnt_r + 4'h1 == dtarget_r
      |=> state_r == S_DATA && io_oe_r == 4'h0)
      else $error("data phase not entered when dummy count reached");
   a_mode_capture: assert property ( // RQ3 RQ9
      state_r == S_DUMMY && sck_rise && !cs_hi && !cs_fall && cnt_r == 4'h1
      |=> mode_r == {$past(mode_r[3:0]), $past(io_q)})
      else $error("second mode nibble not captured in second dummy cycle");
   a_fetch_aligned: assert property ( // RQ6 RQ10
      state_r == S_DUMMY && aligned_cmd_r |-> addr_r[1:0] == 2'h0)
      else $error("aligned fetch kept low address bits");
   a_flag_aligned: assert property ( // RQ4 RQ5
      state_r == S_ADDR && sck_rise && !cs_hi && !cs_fall && cnt_r == `QRDC_ADDR_LAST_NIB
         && !aligned_cmd_r
      |=> addr_r[1:0] == ($past(dwa_sel) ? 2'h0 : $past(io_q[1:0])))
      else $error("byte address alignment disagrees with flag");
   a_oe_in_data: assert property ( // RQ11
      io_oe_r != 4'h0 |-> state_r == S_DATA || $past(state_r) == S_DATA)
      else $error("lanes driven outside the data phase");
   a_high_nibble: assert property ( // RQ11
      state_r == S_DATA && sck_fall && !cs_hi && nib_hi_r
      |=> io_out_r == $past(cur_byte[7:4]) && io_oe_r == 4'hF && !nib_hi_r)
      else $error("high nibble not driven first");
   a_skip_command: assert property ( // RQ9
      cs_fall && xip_r |=> state_r == S_ADDR && cnt_r == 4'h0)
      else $error("continuous fetch frame did not start at address");
endmodule : qrdc_top
`default_nettype wire

// *** rtl/qrdc_map.svh ***
// register map, field positions and link constants of the quad fetch dummy cycle block
// Contract
// [RQ1] dummy count comes from status-5 bits 6:4
// [RQ2] codes 000..100 give 2,4,6,8,10 cycles
// [RQ3] dummy count includes two mode-byte cycles
// [RQ4] alignment flag is status-5 bit 0
// [RQ5] EBh: any address, or aligned when flag set
// [RQ6] E7h always aligned, flag ignored
// [RQ7] host picks setting suiting its SCK rate
// [RQ8] host lowers SCK in wrap mode
// [RQ9] mode byte after address selects continuous fetch
// [RQ10] E7h forces address bits 1:0 to zero
// [RQ11] after dummies drive four lanes, high nibble first
// [RQ12] count dummies after address, then drive data
`ifndef QRDC_MAP_SVH
`define QRDC_MAP_SVH

`define QRDC_SR5_OFFS      12'h000
`define QRDC_STAT_OFFS     12'h004
`define QRDC_MEM_BASE      12'h100
`define QRDC_MEM_LAST      12'h1FC
`define QRDC_SR5_RST       8'h00
`define QRDC_SR5_WMASK     8'h71
`define QRDC_DC_MSB        6
`define QRDC_DC_LSB        4
`define QRDC_DWA_BIT       0
`define QRDC_ST_XIP        0
`define QRDC_ST_ACT        1
`define QRDC_ST_STATE_LSB  4
`define QRDC_ST_CMD_LSB    8
`define QRDC_RESP_OKAY     2'h0
`define QRDC_RESP_SLVERR   2'h2

`define QRDC_CMD_FETCH     8'hEB
`define QRDC_CMD_FETCH_AL  8'hE7
`define QRDC_CMD_LAST_BIT  4'h7
`define QRDC_ADDR_LAST_NIB 4'h5
`define QRDC_MODE_CYC      4'h2
`define QRDC_XIP_KEEP      4'hA
`define QRDC_ALIGN_MASK    24'hFFFFFC
`define QRDC_ARRAY_MASK    24'h1FFFFF
`define QRDC_DC_CYC0       4'h2
`define QRDC_DC_CYC1       4'h4
`define QRDC_DC_CYC2       4'h6
`define QRDC_DC_CYC3       4'h8
`define QRDC_DC_CYC4       4'hA

`define QRDC_PIN_CS        5
`define QRDC_PIN_SCK       4
`define QRDC_PIN_RST       6'h3F
`define QRDC_MEM_AW        6
`define QRDC_MEM_DEPTH     64

`endif

// *** rtl/qrdc_pkg.sv ***
// types and shared decode of the quad fetch dummy cycle block
`default_nettype none
`include "qrdc_map.svh"
package qrdc_pkg;
   typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP} qrdc_state_e;
   typedef enum logic [1:0] {SEL_SR5, SEL_STAT, SEL_MEM, SEL_NONE} qrdc_sel_e;

   // undefined codes saturate at the longest setting
   function automatic logic [3:0] qrdc_dummy_count(input logic [2:0] code);
      case (code)
         3'h0:    qrdc_dummy_count = `QRDC_DC_CYC0;
         3'h1:    qrdc_dummy_count = `QRDC_DC_CYC1;
         3'h2:    qrdc_dummy_count = `QRDC_DC_CYC2;
         3'h3:    qrdc_dummy_count = `QRDC_DC_CYC3;
         default: qrdc_dummy_count = `QRDC_DC_CYC4;
      endcase
   endfunction : qrdc_dummy_count
endpackage : qrdc_pkg
`default_nettype wire

// *** rtl/qrdc_mem.sv ***
// array image read by the fetch engine, byte-write port for software
`timescale 1ns/1ps
`default_nettype none
`include "qrdc_map.svh"
module qrdc_mem
   import qrdc_pkg::*;
(
   // clock
   input  wire logic                    clk,
   // write port
   input  wire logic                    wr_en,
   input  wire logic [3:0]              wr_be,
   input  wire logic [`QRDC_MEM_AW-1:0] wr_addr,
   input  wire logic [31:0]             wr_data,
   // read port
   input  wire logic [`QRDC_MEM_AW-1:0] rd_addr,
   output var  logic [31:0]             rd_data
);
   logic [7:0]  lane_q [4];
   logic [31:0] rd_nxt;

   // one array per byte lane, so every array has a single writing process
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         logic [7:0] lane_r [`QRDC_MEM_DEPTH];
         always_ff @(posedge clk) begin
            if (wr_en && wr_be[b]) begin
               lane_r[wr_addr] <= wr_data[b*8 +: 8];
            end
         end
         assign lane_q[b] = lane_r[rd_addr];
      end
   endgenerate

   always_comb begin
      rd_nxt = {lane_q[3], lane_q[2], lane_q[1], lane_q[0]};
   end

   always_ff @(posedge clk) begin
      rd_data <= rd_nxt;
   end
endmodule : qrdc_mem
`default_nettype wire

// *** testbench/qrdc_host.sv ***
// quad fetch host model: drives the link clock, select and lanes, samples returned nibbles
`timescale 1ns/1ps
`default_nettype none
`include "qrdc_map.svh"
module qrdc_host (
   // link outputs
   output var  logic       sck,
   output var  logic       cs_n,
   output var  logic [3:0] drv,
   // resolved lanes and device enable
   input  wire logic [3:0] io,
   input  wire logic [3:0] oe
);
   logic [3:0] rx_q[$];
   logic [3:0] smp;
   int         oe_err;
   logic       xip_r;

   // sck half period 40 ns: far below every rate limit of any setting
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      drv = 4'h0;
      xip_r = 1'b0;
      oe_err = 0;
   end

   // sample just before the rising edge, the device moved its nibble on the falling one
   task automatic tick(input logic [3:0] v, input logic [3:0] eo);
      drv = v;
      #40;
      smp = io;
      if (oe !== eo) oe_err++;
      sck = 1'b1;
      #40 sck = 1'b0;
   endtask : tick

   // sck stands low outside frames; released lanes toggle so stale values never look valid
   task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input logic [7:0] m,
                        input int nd, input int nn, input logic [3:0] data_oe);
      int i;
      rx_q.delete();
      oe_err = 0;
      #1.3 cs_n = 1'b0;
      #40;
      if (!xip_r) for (i = 7; i >= 0; i--) tick({3'h0, cmd[i]}, 4'h0);
      for (i = 5; i >= 0; i--) tick(a[i*4+:4], 4'h0);
      for (i = 0; i < nd; i++) tick(i == 0 ? m[7:4] : (i == 1 ? m[3:0] : ~drv), 4'h0);
      xip_r = (data_oe != 4'h0) && (m[7:4] == `QRDC_XIP_KEEP);
      for (i = 0; i < nn; i++) begin
         tick(~drv, data_oe);
         rx_q.push_back(smp);
      end
      #40 cs_n = 1'b1;
      #200;
   endtask : frame
endmodule : qrdc_host
`default_nettype wire

// *** testbench/tb_quad_read_dummy_cycle_config.sv ***
// self-checking bench: register bus master, host model and reference image
`timescale 1ns/1ps
`default_nettype none
`include "qrdc_map.svh"
module tb_quad_read_dummy_cycle_config
   import qrdc_pkg::*;
;
   logic        ref_clk, rstn;
   logic [11:0] awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, io_out, io_oe, io_in, host_drv;
   logic [1:0]  bresp, rresp;
   logic        sck, cs_n;
   logic [7:0]  mem_b[256];
   logic [7:0]  ref_cmd;
   logic        ref_xip;
   int          n_errors, checks, cyc;

   qrdc_top i_dut (.ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   qrdc_host i_host (.sck(sck), .cs_n(cs_n), .drv(host_drv), .io(io_in), .oe(io_oe));

   // lane level resolved from both drivers
   assign io_in = (io_oe & io_out) | (~io_oe & host_drv);

   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;

   task automatic finish_test();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   // longest path is about 40 frames of under 900 cycles each
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      bit ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge ref_clk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask : axi_rd

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      check(r, er);
      check(d & m, e);
   endtask : rd_chk

   // reference: count from code, alignment from command or flag, nibbles high first
   task automatic fetch(input logic [7:0] cmd, input logic [23:0] a, input logic [7:0] m,
                        input int code, input bit fl, input int nn);
      int nd, k;
      bit ok;
      logic [23:0] e;
      logic [7:0] b;
      nd = code > 4 ? 10 : 2 * code + 2;
      if (!ref_xip) ref_cmd = cmd;
      ok = ref_cmd == `QRDC_CMD_FETCH || ref_cmd == `QRDC_CMD_FETCH_AL;
      e = (ref_cmd == `QRDC_CMD_FETCH_AL || fl) ? a & `QRDC_ALIGN_MASK : a;
      i_host.frame(cmd, a, m, nd, nn, ok ? 4'hF : 4'h0);
      check(i_host.oe_err, 0);
      for (k = 0; ok && k < nn; k++) begin
         b = mem_b[((e + k / 2) & `QRDC_ARRAY_MASK) % 256];
         check(i_host.rx_q[k], k % 2 ? b[3:0] : b[7:4]);
      end
      ref_xip = ok && m[7:4] == `QRDC_XIP_KEEP;
      @(posedge ref_clk);
      check(io_oe, 4'h0);
   endtask : fetch

   initial begin
      logic [1:0]  r;
      logic [31:0] d;
      logic [3:0]  s;
      logic [23:0] a;
      int          i, c, f;
      void'($urandom(32'h1A49));
      rstn = 1'b0;
      awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
      araddr = 12'h000; arvalid = 1'b0; rready = 1'b0;
      ref_xip = 1'b0;
      ref_cmd = 8'h00;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd_chk(`QRDC_SR5_OFFS, 32'hFFFFFFFF, 32'h0, `QRDC_RESP_OKAY);
      rd_chk(`QRDC_STAT_OFFS, 32'h1, 32'h0, `QRDC_RESP_OKAY);
      rd_chk(12'h008, 32'h0, 32'h0, `QRDC_RESP_SLVERR);
      rd_chk(`QRDC_MEM_BASE, 32'hFFFFFFFF, 32'h0, `QRDC_RESP_OKAY);
      axi_wr(`QRDC_SR5_OFFS, 32'hFFFFFFFF, 4'hF, r);
      check(r, `QRDC_RESP_OKAY);
      axi_wr(`QRDC_SR5_OFFS, 32'h0, 4'hE, r);
      rd_chk(`QRDC_SR5_OFFS, 32'hFFFFFFFF, 32'h71, `QRDC_RESP_OKAY);
      axi_wr(`QRDC_STAT_OFFS, 32'hFFFFFFFF, 4'hF, r);
      check(r, `QRDC_RESP_OKAY);
      axi_wr(12'h00C, 32'h0, 4'hF, r);
      check(r, `QRDC_RESP_SLVERR);
      for (i = 0; i < 80; i++) begin
         d = $urandom;
         s = i < 64 ? 4'hF : 4'($urandom);
         axi_wr(`QRDC_MEM_BASE + 12'(4 * (i % 64)), d, s, r);
         for (c = 0; c < 4; c++) if (s[c]) mem_b[4 * (i % 64) + c] = d[8*c+:8];
      end
      // every code, both commands, both flag values; odd counts cut a byte short
      for (i = 0; i < 32; i++) begin
         c = i / 4;
         f = i % 2;
         axi_wr(`QRDC_SR5_OFFS, 32'(c * 16 + f), 4'hF, r);
         a = i % 4 == 3 ? 24'h1FFFFD : 24'($urandom) & `QRDC_ARRAY_MASK;
         fetch(i % 4 < 2 ? `QRDC_CMD_FETCH : `QRDC_CMD_FETCH_AL, a, 8'($urandom) & 8'h5F, c, f, 7 + i % 2);
      end
      // continuous mode keeps the aligned command across a frame with no command
      axi_wr(`QRDC_SR5_OFFS, 32'h10, 4'hF, r);
      fetch(`QRDC_CMD_FETCH_AL, 24'h000123, 8'hA5, 1, 0, 4);
      rd_chk(`QRDC_STAT_OFFS, 32'h1, 32'h1, `QRDC_RESP_OKAY);
      fetch(`QRDC_CMD_FETCH, 24'h000047, 8'h00, 1, 0, 6);
      rd_chk(`QRDC_STAT_OFFS, 32'h1, 32'h0, `QRDC_RESP_OKAY);
      fetch(8'h03, 24'h000010, 8'h00, 1, 0, 6);
      finish_test();
   end
endmodule : tb_quad_read_dummy_cycle_config
`default_nettype wire
